// [pkg/bsrq_pkg.sv]
// package for the breaker status / reclose qualifier: register map, fields, timing
package bsrq_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] BSRQ_CTRL_OFF   = 8'h00;
   localparam logic [7:0] BSRQ_STATUS_OFF = 8'h04;
   localparam logic [7:0] BSRQ_COUNT_OFF  = 8'h08;

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int         BSRQ_CTRL_ASSIGN_BIT = 0;  // status function assigned to input
   localparam int         BSRQ_CTRL_INVERT_BIT = 1;  // inverted (b contact) form
   localparam int         BSRQ_CTRL_PERMIT_BIT = 2;  // permit option assigned
   localparam logic [2:0] BSRQ_CTRL_RESET      = 3'h3;

   // ------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------
   localparam int BSRQ_STAT_OPEN_BIT     = 0;  // breaker deemed open
   localparam int BSRQ_STAT_RAW_BIT      = 1;  // synchronised open indication
   localparam int BSRQ_STAT_PERMIT_BIT   = 2;  // permit input level
   localparam int BSRQ_STAT_INIT_CNT_LSB = 8;  // count of reclose initiations
   localparam int BSRQ_STAT_INIT_CNT_W   = 8;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          BSRQ_SYS_HZ       = 60;           // power-system frequency
   localparam int          BSRQ_QUAL_CYCLES  = 10;           // qualification, power cycles
   localparam longint      BSRQ_CLK_HZ       = 100000000;
   localparam longint      BSRQ_CYC_CLKS     = BSRQ_CLK_HZ / BSRQ_SYS_HZ;
   localparam logic [31:0] BSRQ_QUAL_CLKS    = 32'(BSRQ_CYC_CLKS * BSRQ_QUAL_CYCLES);
   localparam int          BSRQ_CNT_W        = 32;

   // apb request carried as one bundle
   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } bsrq_apb_req_t;

endpackage

// [src/bsrq_qual_timer.sv]
// persistence timer: qualifies a level that must hold for a fixed time
`timescale 1ns/1ps
module bsrq_qual_timer
   import bsrq_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // level to qualify and limit
   input  wire logic                  level_i,
   input  wire logic [BSRQ_CNT_W-1:0] limit_i,
   // result
   output logic                       qualified_o,
   output logic [BSRQ_CNT_W-1:0]      count_o
);

   logic [BSRQ_CNT_W-1:0] count_ff;
   logic [BSRQ_CNT_W-1:0] nxt_count;
   logic                  qual_ff;
   logic                  nxt_qual;
   wire                   done_w = (count_ff >= limit_i - 32'h1);

   // count restarts from zero whenever the level drops early
   assign nxt_count = !level_i ? '0 : (qual_ff ? count_ff : count_ff + 32'h1);
   assign nxt_qual  = level_i & (qual_ff | done_w);

   // timer state
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         count_ff <= '0;
         qual_ff  <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         qual_ff  <= nxt_qual;
      end
   end

   assign qualified_o = qual_ff;
   assign count_o     = count_ff;

endmodule

// [src/bsrq_top.sv]
// breaker status qualification and reclose initiate with apb registers
//
// What this block does
// - inverted assignment makes one input both breaker position and reclose initiate
// - with inverted form, input de-energised to energised means breaker opening
// - open indication must persist ten power cycles before breaker deemed open
// - open indication shorter than ten cycles keeps breaker closed, no reclose
// - after full qualification breaker marked open; in inverted form the reclose cycle starts
// - permit option assigned and permit input de-energised suppresses automatic reclose
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module bsrq_top
   import bsrq_pkg::*;
#(
   parameter logic [31:0] QUAL_CLKS = BSRQ_QUAL_CLKS
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // debounced control inputs (asynchronous to clk_i)
   input  wire logic        breaker_status_reclose_input_i,
   input  wire logic        reclose_permit_input_i,
   // results
   output logic             breaker_open_o,
   output logic             reclose_initiate_o
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [1:0] stat_sync_ff;
   logic [1:0] perm_sync_ff;

   // two flops each; only the second stage is read below
   // both reset low: permit reads absent for two cycles, far shorter than any qualification
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stat_sync_ff <= 2'h0;
         perm_sync_ff <= 2'h0;
      end
      else
      begin
         stat_sync_ff <= {stat_sync_ff[0], breaker_status_reclose_input_i};
         perm_sync_ff <= {perm_sync_ff[0], reclose_permit_input_i};
      end
   end

   wire stat_lvl_w = stat_sync_ff[1];
   wire perm_lvl_w = perm_sync_ff[1];

   // ------------------------------------------------------------
   // apb register file
   // ------------------------------------------------------------
   // one 32-bit word per register, byte addresses:
   //   0x00 control: bit 0 function assigned, bit 1 inverted form, bit 2 permit option
   //   0x04 status, read only: bit 0 deemed open, bit 1 open indication,
   //        bit 2 permit level, bits 15:8 initiations counted
   //   0x08 qualification counter, read only
   // any other offset answers with slave error, reads zero and drops writes
   bsrq_apb_req_t req_w;
   logic [2:0]    ctrl_ff;
   logic [2:0]    nxt_ctrl;
   logic [31:0]   prdata_ff;
   logic [31:0]   nxt_prdata;
   logic          pslverr_ff;
   logic          pready_ff;

   assign req_w = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

   // full address compare; a partial decode would alias the map into the unmapped space
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
      return (addr == off);
   endfunction

   // decode: zero-wait-state slave, answers in the first access cycle after setup
   wire acc_w      = req_w.psel & req_w.penable & pready_ff;
   wire setup_w    = req_w.psel & ~req_w.penable;
   wire hit_ctrl_w = addr_hit(req_w.paddr, BSRQ_CTRL_OFF);
   wire hit_stat_w = addr_hit(req_w.paddr, BSRQ_STATUS_OFF);
   wire hit_cnt_w  = addr_hit(req_w.paddr, BSRQ_COUNT_OFF);
   wire mapped_w   = hit_ctrl_w | hit_stat_w | hit_cnt_w;
   wire wr_ctrl_w  = acc_w & req_w.pwrite & hit_ctrl_w;

   // control fields; flipping the form mid-episode inverts the indication, so the count restarts
   wire assigned_w = ctrl_ff[BSRQ_CTRL_ASSIGN_BIT];
   wire inverted_w = ctrl_ff[BSRQ_CTRL_INVERT_BIT];
   wire permit_on_w = ctrl_ff[BSRQ_CTRL_PERMIT_BIT];

   // only the access edge writes; a setup cycle alone never changes the control word
   assign nxt_ctrl = wr_ctrl_w ? pwdata_i[2:0] : ctrl_ff;

   // ------------------------------------------------------------
   // open indication and qualification
   // ------------------------------------------------------------
   logic                  qualified_w;
   logic [BSRQ_CNT_W-1:0] count_w;

   // inverted form: energised b contact means the breaker is opening;
   // plain form: de-energised a contact means open
   wire open_ind_w = assigned_w & (inverted_w ? stat_lvl_w : ~stat_lvl_w);

   // a b contact racing the seal-in auxiliary contact can energise the input briefly;
   // the timer below is what keeps that race from starting a reclose
   // the limit is a fixed count of clocks, so an off-nominal system frequency shifts it slightly
   // short open pulses (contact race) never reach the qualified level
   bsrq_qual_timer u_timer
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .level_i     (open_ind_w),
      .limit_i     (QUAL_CLKS),
      .qualified_o (qualified_w),
      .count_o     (count_w)
   );

   // ------------------------------------------------------------
   // breaker state and reclose initiate
   // ------------------------------------------------------------
   logic       open_ff;
   logic       init_ff;
   logic [7:0] init_cnt_ff;
   logic       nxt_open;
   logic       nxt_init;

   // permit low blocks initiation only when the option is assigned
   // the breaker is still marked open while blocked; only the reclose start is held back
   // the breaker reads closed again one clock after the qualified level drops
   wire permit_ok_w = ~permit_on_w | perm_lvl_w;
   wire open_rise_w = qualified_w & ~open_ff;
   assign nxt_open  = qualified_w;
   assign nxt_init  = open_rise_w & inverted_w & permit_ok_w;

   // state flops; initiate is a one-cycle pulse per permitted qualified opening in inverted form
   // the initiation count wraps at 255, so software tracks it by differences
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         open_ff     <= 1'b0;
         init_ff     <= 1'b0;
         init_cnt_ff <= 8'h00;
      end
      else
      begin
         open_ff     <= nxt_open;
         init_ff     <= nxt_init;
         init_cnt_ff <= init_cnt_ff + {7'h00, nxt_init};
      end
   end

   // ------------------------------------------------------------
   // read mux and bus response
   // ------------------------------------------------------------
   // status word packed from the field positions of the register map
   function automatic logic [31:0] pack_status
   (
      input logic       is_open,
      input logic       is_ind,
      input logic       permit_lvl,
      input logic [7:0] cnt_init
   );
      logic [31:0] word;
      word = 32'h0;
      word[BSRQ_STAT_OPEN_BIT] = is_open;
      word[BSRQ_STAT_RAW_BIT] = is_ind;
      word[BSRQ_STAT_PERMIT_BIT] = permit_lvl;
      word[BSRQ_STAT_INIT_CNT_LSB +: BSRQ_STAT_INIT_CNT_W] = cnt_init;
      return word;
   endfunction

   wire [31:0] stat_word_w = pack_status(open_ff, open_ind_w, perm_lvl_w, init_cnt_ff);

   // a read setup loads new data; a write setup clears the read word to zero
   assign nxt_prdata = !(setup_w & ~req_w.pwrite) ? 32'h0 :
                       hit_ctrl_w ? {29'h0, ctrl_ff} :
                       hit_stat_w ? stat_word_w :
                       hit_cnt_w  ? count_w : 32'h0;

   // bus flops: data latched in setup so it stands through the access
   // ready is registered from setup, so every transfer takes exactly one access cycle
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_ff    <= BSRQ_CTRL_RESET;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
         pready_ff  <= 1'b0;
      end
      else
      begin
         ctrl_ff    <= nxt_ctrl;
         prdata_ff  <= setup_w ? nxt_prdata : prdata_ff;
         pslverr_ff <= setup_w & ~mapped_w;
         pready_ff  <= setup_w;
      end
   end

   assign prdata_o           = prdata_ff;
   assign pready_o           = pready_ff;
   assign pslverr_o          = pslverr_ff;
   assign breaker_open_o     = open_ff;
   assign reclose_initiate_o = init_ff;

endmodule

// [verif/bsrq_contacts.sv]
// breaker auxiliary and permit contact model for the qualifier bench
`timescale 1ns/1ps
module bsrq_contacts
(
   // clock, reset and command
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic [15:0] len_i,
   input  wire logic        permit_i,
   // contact levels
   output logic             status_o,
   output logic             permit_o
);
   logic [15:0] left_ff;
   // b contact closes for len cycles; a dry contact rests de-energised, not floating
   // reset keeps the contact open, so the pin never shows an unknown level
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         left_ff <= 16'h0;
      else if (go_i)
         left_ff <= len_i;
      else if (left_ff != 16'h0)
         left_ff <= left_ff - 16'h1;
   assign status_o = (left_ff != 16'h0);
   assign permit_o = permit_i;
endmodule

// [verif/bsrq_top_properties.sv]
// concurrent checks on the qualifier top level ports
`timescale 1ns/1ps
module bsrq_top_properties
   import bsrq_pkg::*;
#(
   parameter logic [31:0] QUAL_CLKS = BSRQ_QUAL_CLKS
)
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        breaker_status_reclose_input_i,
   input wire logic        reclose_permit_input_i,
   input wire logic        breaker_open_o,
   input wire logic        reclose_initiate_o
);
   logic [2:0]  ctrl_ff;
   logic [31:0] run_ff;
   logic [3:0]  plow_ff;
   wire         wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == BSRQ_CTRL_OFF;
   wire         ind = ctrl_ff[0] && ctrl_ff[1] && breaker_status_reclose_input_i;
   // shadow control, pin run length and permit low time; pin is raw, so no sync lag here
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
      begin
         ctrl_ff <= BSRQ_CTRL_RESET;
         run_ff  <= 32'h0;
         plow_ff <= 4'h0;
      end
      else
      begin
         ctrl_ff <= wr_ctrl ? pwdata_i[2:0] : ctrl_ff;
         run_ff  <= ind ? run_ff + 32'h1 : 32'h0;
         plow_ff <= reclose_permit_input_i ? 4'h0 : plow_ff + {3'h0, plow_ff != 4'hf};
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_gone;
      (ctrl_ff[1] && !breaker_status_reclose_input_i) [*5];
   endsequence
   a_pready_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_err_unmapped: assert property (pready_o |-> pslverr_o == (paddr_i > BSRQ_COUNT_OFF || paddr_i[1:0] != 2'h0))
      else $error("slave error mismatch");
   a_open_not_early: assert property ($rose(breaker_open_o) && ctrl_ff[1] |-> run_ff >= QUAL_CLKS)
      else $error("open before qualification");
   a_open_on_time: assert property (run_ff == QUAL_CLKS + 32'h5 |-> breaker_open_o)
      else $error("open missing after qualification");
   a_open_drops: assert property (s_gone |-> !breaker_open_o)
      else $error("open held after indication left");
   a_init_on_open: assert property (reclose_initiate_o |-> $rose(breaker_open_o))
      else $error("initiate without opening");
   a_init_inverted: assert property (reclose_initiate_o |-> ctrl_ff[1] && ctrl_ff[0])
      else $error("initiate in plain form");
   a_permit_block: assert property (reclose_initiate_o && ctrl_ff[2] |-> plow_ff < 4'h4)
      else $error("initiate while permit low");
   a_init_pulse: assert property (reclose_initiate_o |=> !reclose_initiate_o)
      else $error("initiate longer than a cycle");
endmodule
bind bsrq_top bsrq_top_properties #(.QUAL_CLKS(QUAL_CLKS)) i_props (.clk_i(clk_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .reclose_permit_input_i(reclose_permit_input_i),
   .breaker_status_reclose_input_i(breaker_status_reclose_input_i), .breaker_open_o(breaker_open_o),
   .reclose_initiate_o(reclose_initiate_o));

// [verif/tb.sv]
// self-checking bench for the breaker status qualifier
`timescale 1ns/1ps
module tb;
   import bsrq_pkg::*;
   localparam int Q = 20;
   logic clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, perm = 1'b1, st, pm, bo, ri, rdy, err;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  padr = 8'h0;
   logic [15:0] len = 16'h0;
   logic [31:0] pwd = 32'h0, prd, r;
   logic        e;
   int n_errors = 0, checks = 0, n_init = 0, n_open = 0, exp_init = 0;
   always #5 clk_i = ~clk_i;
   bsrq_top #(.QUAL_CLKS(32'(Q))) i_bsrq_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
      .breaker_status_reclose_input_i(st), .reclose_permit_input_i(pm), .breaker_open_o(bo),
      .reclose_initiate_o(ri));
   bsrq_contacts i_bsrq_contacts (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len), .permit_i(perm),
      .status_o(st), .permit_o(pm));
   // tallies of initiate pulses and open cycles
   always @(posedge clk_i)
   begin
      n_init <= n_init + (ri === 1'b1);
      n_open <= n_open + (bo === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   // apb transfer; data and error are taken at the rising edge at which ready is high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      @(posedge clk_i);
      while (rdy !== 1'b1)
         @(posedge clk_i);
      r = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // close the b contact for n cycles, then return gap cycles after it opens again
   task automatic pulse(input int n, input int gap);
      @(posedge clk_i);
      go <= 1'b1;
      len <= 16'(n);
      @(posedge clk_i);
      go <= 1'b0;
      repeat (n + gap) @(posedge clk_i);
   endtask
   // open stands from the last qualifying sample to the first sample after the indication leaves
   function automatic int open_span(input int n);
      return (n < Q) ? 0 : n - Q + 1;
   endfunction
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles of the sequence
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      void'($urandom(32'h9878));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b0, BSRQ_CTRL_OFF, 32'h0);
      chk("ctrl", {29'h0, BSRQ_CTRL_RESET}, r);
      apb(1'b1, 8'h0c, 32'h5);
      chk("err", 1, e);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped data", 0, r);
      chk("unmapped err", 1, e);
      pulse(Q - 1, Q + 12);
      for (int k = 0; k < 4; k++)
         pulse(1 + $urandom % (Q - 1), Q + 12);
      // two short closures split by a two-cycle gap: long enough together, too short apart
      pulse(Q - 4, 0);
      pulse(Q - 4, Q + 12);
      chk("short opens", 0, n_open);
      chk("short inits", 0, n_init);
      pulse(Q + 10, Q + 12);
      exp_init++;
      chk("open span", open_span(Q + 10), n_open);
      chk("first init", exp_init, n_init);
      apb(1'b1, BSRQ_CTRL_OFF, 32'h7);
      apb(1'b0, BSRQ_CTRL_OFF, 32'h0);
      chk("ctrl write", 7, r);
      perm <= 1'b0;
      pulse(Q + 10 + $urandom % 8, Q + 12);
      perm <= 1'b1;
      pulse(Q + 10, Q + 12);
      exp_init++;
      apb(1'b0, BSRQ_STATUS_OFF, 32'h0);
      chk("init count", exp_init, {24'h0, r[15:8]});
      chk("initiates", exp_init, n_init);
      apb(1'b1, BSRQ_CTRL_OFF, 32'h1);
      repeat (Q + 10) @(posedge clk_i);
      chk("plain open", 1, bo);
      chk("plain init", exp_init, n_init);
      apb(1'b0, BSRQ_STATUS_OFF, 32'h0);
      chk("plain status", {16'h0, exp_init[7:0], 8'h07}, r);
      apb(1'b0, BSRQ_COUNT_OFF, 32'h0);
      chk("qual count", Q, r);
      // reset in mid-run drops the open state and restores the control word
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("reset open", 0, bo);
      rst_i <= 1'b0;
      apb(1'b0, BSRQ_CTRL_OFF, 32'h0);
      chk("reset ctrl", {29'h0, BSRQ_CTRL_RESET}, r);
      report_and_stop();
   end
endmodule
